// >>> core/main_clock_rtc_beeper.v
// Main clock controller: slow-mode prescaler, clock out, tick timer and tone output
//
// Operation
// RULE1: clock_out_enable drives core clock onto pin; pin toggles at half core rate undivided, stays high at slow divide 2
// RULE2: clock out suspended during timed halt
// RULE3: slow divider codes give divide 2,4,8,16
// RULE4: slow_mode_select picks undivided or divided clock
// RULE5: period_select picks 16000/32000/80000/200000 cycles
// RULE6: new period applies after current period
// RULE7: tick_flag set each elapsed period
// RULE8: status read clears tick_flag; writes never set
// RULE9: enabled tick interrupt wakes timed halt
// RULE10: halt with irq enable enters timed halt
// RULE11: software avoids bit set/clear on status
// RULE12: tone codes give off, 2k, 1k, 500 Hz
// RULE13: tone keeps running in timed halt
// RULE14: software writes zero to tone bits 7:2
// RULE15: both registers reset to zero
// RULE16: tick interrupt gated by enable and mask
// RULE17: full halt freezes counter and registers
// RULE18: tick counter free-runs, sets flag every period
`timescale 1ns/1ns
`include "mcc_defs.vh"
module main_clock_rtc_beeper #(
	parameter TICK_P0 = `TICK_CYC_0,
	parameter TICK_P1 = `TICK_CYC_1,
	parameter TICK_P2 = `TICK_CYC_2,
	parameter TICK_P3 = `TICK_CYC_3,
	parameter TONE_H1 = `OSC_HZ / (2 * `TONE_HZ_1),
	parameter TONE_H2 = TONE_H1 * `TONE_HZ_1 / `TONE_HZ_2,
	parameter TONE_H3 = TONE_H1 * `TONE_HZ_1 / `TONE_HZ_3
) (
	// Clock and reset
	input wire mclk,
	input wire reset_n,
	// Avalon-MM slave
	input wire [9:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	output reg [31:0] readdata_q,
	output reg waitrequest_q,
	// Processor side
	input wire halt_req,
	input wire irq_mask,
	input wire ext_wake,
	output reg tick_irq_q,
	output reg core_clk_en_q,
	output reg timed_halt_q,
	output reg full_halt_q,
	// Port pins
	output reg clkout_port_pin_q,
	output reg clkout_port_oe_q,
	output reg tone_port_pin_q,
	output reg tone_port_oe_q,
	// Event interrupt
	output reg irq_q
);
	localparam TW = 18;
	localparam [2:0] ST_RUN = 3'b001;
	localparam [2:0] ST_TIMED = 3'b010;
	localparam [2:0] ST_FULL = 3'b100;
	localparam [7:0] RST_CTRL = `RST_CLK_CTRL_STATUS;
	localparam [7:0] RST_TONE = `RST_TONE_CTRL;

	// Decode of a byte address against a register index
	function hit;
		input [9:0] addr;
		input [7:0] idx;
		begin
			hit = (addr == {idx, 2'b00});
		end
	endfunction

	// Tick period in cycles for a code
	function [TW-1:0] tick_len;
		input [1:0] code;
		begin
			case (code)
			2'b00: tick_len = TICK_P0[TW-1:0];
			2'b01: tick_len = TICK_P1[TW-1:0];
			2'b10: tick_len = TICK_P2[TW-1:0];
			default: tick_len = TICK_P3[TW-1:0];
			endcase
		end
	endfunction

	// Register state
	reg clock_out_enable_q;
	reg [1:0] slow_divider_select_q;
	reg slow_mode_select_q;
	reg [1:0] period_select_q;
	reg tick_irq_enable_q;
	reg tick_flag_q;
	reg tick_flag_d;
	reg [1:0] tone_select_q;
	reg [1:0] evt_status_q;
	reg [1:0] evt_status_d;
	reg [1:0] evt_enable_q;
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [TW-1:0] period_cur_q;
	reg [3:0] div_cnt_q;
	reg [3:0] div_last;
	reg core_phase_q;
	reg [31:0] rd_mux;
	reg wake_evt;
	reg [TW-1:0] tone_last;

	wire req = read | write;
	wire done = req & ~waitrequest_q;
	wire in_run = state_q[0];
	wire frozen = state_q[2];
	wire wr_ok = done & write & in_run;
	wire tick_wrap;
	wire tone_wrap;

	// Bus answer one cycle after the request appears
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			waitrequest_q <= 1'b1;
			readdata_q <= 32'h0000_0000;
		end else if (req & waitrequest_q) begin
			waitrequest_q <= 1'b0;
			readdata_q <= rd_mux;
		end else begin
			waitrequest_q <= 1'b1;
		end
	end

	always @* begin
		rd_mux = 32'h0000_0000;
		if (hit(address, `IDX_CLK_CTRL_STATUS)) begin
			rd_mux[`BIT_CLOCK_OUT_ENABLE] = clock_out_enable_q;
			rd_mux[`BIT_SLOW_DIV_HI:`BIT_SLOW_DIV_LO] = slow_divider_select_q;
			rd_mux[`BIT_SLOW_MODE_SELECT] = slow_mode_select_q;
			rd_mux[`BIT_PERIOD_HI:`BIT_PERIOD_LO] = period_select_q;
			rd_mux[`BIT_TICK_IRQ_ENABLE] = tick_irq_enable_q;
			rd_mux[`BIT_TICK_FLAG] = tick_flag_q;
		end else if (hit(address, `IDX_TONE_CTRL)) begin
			rd_mux[`BIT_TONE_HI:`BIT_TONE_LO] = tone_select_q;
		end else if (hit(address, `IDX_EVT_STATUS)) begin
			rd_mux[1:0] = evt_status_q;
		end else if (hit(address, `IDX_EVT_ENABLE)) begin
			rd_mux[1:0] = evt_enable_q;
		end
	end

	// Control registers; no writes land while halted
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			clock_out_enable_q <= RST_CTRL[`BIT_CLOCK_OUT_ENABLE]; // RULE15
			slow_divider_select_q <= RST_CTRL[`BIT_SLOW_DIV_HI:`BIT_SLOW_DIV_LO];
			slow_mode_select_q <= RST_CTRL[`BIT_SLOW_MODE_SELECT];
			period_select_q <= RST_CTRL[`BIT_PERIOD_HI:`BIT_PERIOD_LO];
			tick_irq_enable_q <= RST_CTRL[`BIT_TICK_IRQ_ENABLE];
			tone_select_q <= RST_TONE[`BIT_TONE_HI:`BIT_TONE_LO]; // RULE15
			evt_enable_q <= `RST_EVT;
		end else if (wr_ok) begin
			if (hit(address, `IDX_CLK_CTRL_STATUS)) begin
				clock_out_enable_q <= writedata[`BIT_CLOCK_OUT_ENABLE];
				slow_divider_select_q <= writedata[`BIT_SLOW_DIV_HI:`BIT_SLOW_DIV_LO];
				slow_mode_select_q <= writedata[`BIT_SLOW_MODE_SELECT];
				period_select_q <= writedata[`BIT_PERIOD_HI:`BIT_PERIOD_LO];
				tick_irq_enable_q <= writedata[`BIT_TICK_IRQ_ENABLE];
			end
			// Reserved tone bits are dropped and read back as zero
			if (hit(address, `IDX_TONE_CTRL)) begin
				tone_select_q <= writedata[`BIT_TONE_HI:`BIT_TONE_LO]; // RULE14
			end
			if (hit(address, `IDX_EVT_ENABLE)) begin
				evt_enable_q <= writedata[1:0];
			end
		end
	end

	// Tick flag: only the captured set bit is cleared, so a tick landing
	// between capture and completion of the read is not lost
	always @* begin
		tick_flag_d = tick_flag_q;
		if (done & read & hit(address, `IDX_CLK_CTRL_STATUS) & readdata_q[`BIT_TICK_FLAG]) begin
			tick_flag_d = 1'b0; // RULE8
		end
		if (tick_wrap) begin
			tick_flag_d = 1'b1; // RULE7 RULE18
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tick_flag_q <= 1'b0;
		end else begin
			tick_flag_q <= tick_flag_d;
		end
	end

	// Period change waits for the running period to end
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			period_cur_q <= TICK_P0[TW-1:0];
		end else if (tick_wrap) begin
			period_cur_q <= tick_len(period_select_q); // RULE6
		end
	end

	// Tick counter runs except in full halt
	period_counter #(
		.W(TW)
	) u_tick (
		.mclk(mclk),
		.reset_n(reset_n),
		.run(~frozen), // RULE17 RULE18
		.clear(1'b0),
		.last(period_cur_q - {{(TW-1){1'b0}}, 1'b1}), // RULE5
		.wrap_q(tick_wrap),
		.count_q()
	);

	// Halt state machine
	always @* begin
		state_d = state_q;
		wake_evt = 1'b0;
		case (state_q)
		ST_RUN: begin
			if (halt_req) begin
				state_d = tick_irq_enable_q ? ST_TIMED : ST_FULL; // RULE10
			end
		end
		ST_TIMED: begin
			if (ext_wake | (tick_flag_q & tick_irq_enable_q)) begin
				state_d = ST_RUN; // RULE9
				wake_evt = 1'b1;
			end
		end
		ST_FULL: begin
			if (ext_wake) begin
				state_d = ST_RUN; // RULE17
				wake_evt = 1'b1;
			end
		end
		default: begin
			state_d = ST_RUN;
		end
		endcase
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_RUN;
			timed_halt_q <= 1'b0;
			full_halt_q <= 1'b0;
		end else begin
			state_q <= state_d;
			timed_halt_q <= state_d[1];
			full_halt_q <= state_d[2];
		end
	end

	// Core clock prescaler
	always @* begin
		case (slow_divider_select_q)
		2'b00: div_last = 4'h1;
		2'b01: div_last = 4'h3;
		2'b10: div_last = 4'h7;
		default: div_last = 4'hF;
		endcase // RULE3
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt_q <= 4'h0;
			core_clk_en_q <= 1'b0;
			core_phase_q <= 1'b0;
		end else if (!in_run) begin
			// Core clock stops in either halt
			div_cnt_q <= 4'h0;
			core_clk_en_q <= 1'b0;
		end else if (!slow_mode_select_q) begin
			div_cnt_q <= 4'h0;
			core_clk_en_q <= 1'b1; // RULE4
			core_phase_q <= ~core_phase_q;
		end else begin
			if (div_cnt_q >= div_last) begin
				div_cnt_q <= 4'h0;
				core_clk_en_q <= 1'b1; // RULE4
			end else begin
				div_cnt_q <= div_cnt_q + 4'h1;
				core_clk_en_q <= 1'b0;
			end
			core_phase_q <= (div_cnt_q < (div_last >> 1)) ? 1'b0 : 1'b1;
		end
	end

	// Clock out pin; released to general I/O when disabled
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			clkout_port_pin_q <= 1'b0;
			clkout_port_oe_q <= 1'b0;
		end else begin
			clkout_port_oe_q <= clock_out_enable_q; // RULE1
			clkout_port_pin_q <= clock_out_enable_q & in_run & core_phase_q; // RULE1 RULE2
		end
	end

	// Tone generator: half-period counter toggles the pin
	always @* begin
		case (tone_select_q)
		2'b01: tone_last = TONE_H1[TW-1:0] - {{(TW-1){1'b0}}, 1'b1};
		2'b10: tone_last = TONE_H2[TW-1:0] - {{(TW-1){1'b0}}, 1'b1};
		default: tone_last = TONE_H3[TW-1:0] - {{(TW-1){1'b0}}, 1'b1};
		endcase // RULE12
	end

	period_counter #(
		.W(TW)
	) u_tone (
		.mclk(mclk),
		.reset_n(reset_n),
		.run(~frozen), // RULE13
		.clear(tone_select_q == 2'b00),
		.last(tone_last),
		.wrap_q(tone_wrap),
		.count_q()
	);

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tone_port_pin_q <= 1'b0;
			tone_port_oe_q <= 1'b0;
		end else if (tone_select_q == 2'b00) begin
			tone_port_pin_q <= 1'b0; // RULE12
			tone_port_oe_q <= 1'b0;
		end else begin
			tone_port_oe_q <= 1'b1;
			if (tone_wrap) begin
				tone_port_pin_q <= ~tone_port_pin_q; // RULE12 RULE13
			end
		end
	end

	// Processor tick interrupt
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tick_irq_q <= 1'b0;
		end else begin
			tick_irq_q <= tick_flag_d & tick_irq_enable_q & ~irq_mask; // RULE16 RULE9
		end
	end

	// Sticky event status; a set in the clear cycle wins
	always @* begin
		evt_status_d = evt_status_q;
		if (done & write & hit(address, `IDX_EVT_CLEAR)) begin
			evt_status_d = evt_status_q & ~writedata[1:0];
		end
		if (tick_wrap) begin
			evt_status_d[`EVT_TICK] = 1'b1;
		end
		if (wake_evt) begin
			evt_status_d[`EVT_WAKE] = 1'b1;
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			evt_status_q <= `RST_EVT;
			irq_q <= 1'b0;
		end else begin
			evt_status_q <= evt_status_d;
			irq_q <= |(evt_status_d & evt_enable_q);
		end
	end
endmodule // main_clock_rtc_beeper

// >>> core/mcc_defs.vh
// Offsets, field positions, reset values and timing counts of the clock controller
`ifndef MCC_DEFS_VH
`define MCC_DEFS_VH

// Register indexes; byte address is four times the index
`define IDX_CLK_CTRL_STATUS 8'h2C
`define IDX_TONE_CTRL 8'h2D
`define IDX_EVT_STATUS 8'h30
`define IDX_EVT_CLEAR 8'h31
`define IDX_EVT_ENABLE 8'h32

// Clock control/status fields
`define BIT_CLOCK_OUT_ENABLE 7
`define BIT_SLOW_DIV_HI 6
`define BIT_SLOW_DIV_LO 5
`define BIT_SLOW_MODE_SELECT 4
`define BIT_PERIOD_HI 3
`define BIT_PERIOD_LO 2
`define BIT_TICK_IRQ_ENABLE 1
`define BIT_TICK_FLAG 0

// Tone control fields
`define BIT_TONE_HI 1
`define BIT_TONE_LO 0

// Event status bits
`define EVT_TICK 0
`define EVT_WAKE 1

// Reset values
`define RST_CLK_CTRL_STATUS 8'h00
`define RST_TONE_CTRL 8'h00
`define RST_EVT 2'h0

// Tick periods in oscillator cycles
`define TICK_CYC_0 16000
`define TICK_CYC_1 32000
`define TICK_CYC_2 80000
`define TICK_CYC_3 200000

// Oscillator rate and tone frequencies in Hz
`define OSC_HZ 50000000
`define TONE_HZ_1 2000
`define TONE_HZ_2 1000
`define TONE_HZ_3 500

`endif

// >>> core/period_counter.v
// Free-running modulo counter with a one-cycle wrap pulse
`timescale 1ns/1ns
module period_counter #(
	parameter W = 18
) (
	// Clock and reset
	input wire mclk,
	input wire reset_n,
	// Control
	input wire run,
	input wire clear,
	input wire [W-1:0] last,
	// Status
	output reg wrap_q,
	output reg [W-1:0] count_q
);
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= {W{1'b0}};
			wrap_q <= 1'b0;
		end else if (clear) begin
			count_q <= {W{1'b0}};
			wrap_q <= 1'b0;
		end else if (run) begin
			if (count_q >= last) begin
				count_q <= {W{1'b0}};
				wrap_q <= 1'b1;
			end else begin
				count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
				wrap_q <= 1'b0;
			end
		end else begin
			wrap_q <= 1'b0;
		end
	end
endmodule // period_counter

// >>> dv/mcc_asserts.sv
// Port checks for the clock controller: bus answer, halts, gated interrupt, pins
`timescale 1ns/1ns
module mcc_asserts (
	// Clock and reset
	input wire mclk,
	input wire reset_n,
	// Register bus
	input wire read,
	input wire write,
	input wire [31:0] readdata_q,
	input wire waitrequest_q,
	// Processor side
	input wire irq_mask,
	input wire ext_wake,
	input wire tick_irq_q,
	input wire core_clk_en_q,
	input wire timed_halt_q,
	input wire full_halt_q,
	// Pins
	input wire clkout_port_pin_q,
	input wire tone_port_pin_q,
	input wire tone_port_oe_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_wait_one_cycle: assert property (!waitrequest_q |=> waitrequest_q)
		else $error("waitrequest low for more than one cycle");
	a_answer_next: assert property ((read || write) && waitrequest_q |=> !waitrequest_q)
		else $error("request not answered on the next edge");
	a_read_upper_zero: assert property (!waitrequest_q |-> readdata_q[31:8] == 24'h00_0000)
		else $error("read data above bit 7 not zero");
	a_mask_gates_irq: assert property (irq_mask |=> !tick_irq_q)
		else $error("tick interrupt raised while masked");
	a_halt_exclusive: assert property (timed_halt_q |-> !full_halt_q)
		else $error("timed and full halt together");
	a_full_halt_stays: assert property
		(full_halt_q && !ext_wake && !$past(ext_wake) |=> full_halt_q)
		else $error("full halt left without wake");
	a_core_clk_frozen: assert property (full_halt_q && $past(full_halt_q) |-> !core_clk_en_q)
		else $error("core clock runs in full halt");
	a_clkout_suspended: assert property
		(timed_halt_q && $past(timed_halt_q) && $past(timed_halt_q, 2)
		|-> $stable(clkout_port_pin_q))
		else $error("clock out toggles in timed halt");
	a_tone_idle: assert property
		(!tone_port_oe_q && !$past(tone_port_oe_q) |-> $stable(tone_port_pin_q))
		else $error("tone pin toggles while off");
	a_wake_timed: assert property (timed_halt_q && ext_wake |=> ##[0:2] !timed_halt_q)
		else $error("timed halt not left on wake");
	c_timed: cover property (timed_halt_q ##1 !timed_halt_q);
	c_full: cover property (full_halt_q ##1 !full_halt_q);
	c_tick: cover property (!tick_irq_q ##1 tick_irq_q);
endmodule // mcc_asserts

bind main_clock_rtc_beeper mcc_asserts i_mcc_asserts (.mclk(mclk), .reset_n(reset_n),
	.read(read), .write(write), .readdata_q(readdata_q), .waitrequest_q(waitrequest_q),
	.irq_mask(irq_mask), .ext_wake(ext_wake), .tick_irq_q(tick_irq_q),
	.core_clk_en_q(core_clk_en_q), .timed_halt_q(timed_halt_q), .full_halt_q(full_halt_q),
	.clkout_port_pin_q(clkout_port_pin_q), .tone_port_pin_q(tone_port_pin_q),
	.tone_port_oe_q(tone_port_oe_q));

// >>> dv/tb_top.sv
// Self-checking bench for the clock controller
`timescale 1ns/1ns
module tb_top;
	reg mclk, reset_n, read, write, halt_req, irq_mask, ext_wake, last;
	reg [9:0] address;
	reg [31:0] writedata, rd;
	wire [31:0] readdata_q;
	wire waitrequest_q, tick_irq_q, core_clk_en_q, timed_halt_q, full_halt_q, irq_q;
	wire clkout_port_pin_q, clkout_port_oe_q, tone_port_pin_q, tone_port_oe_q;
	integer errors, checks, cyc, i, n, t0, t1;
	integer per [0:3];
	// Short tick and tone counts keep the run brief
	main_clock_rtc_beeper #(.TICK_P0(40), .TICK_P1(80), .TICK_P2(200), .TICK_P3(500),
		.TONE_H1(4)) i_main_clock_rtc_beeper (
		.mclk(mclk), .reset_n(reset_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata_q(readdata_q), .waitrequest_q(waitrequest_q),
		.halt_req(halt_req), .irq_mask(irq_mask), .ext_wake(ext_wake),
		.tick_irq_q(tick_irq_q), .core_clk_en_q(core_clk_en_q),
		.timed_halt_q(timed_halt_q), .full_halt_q(full_halt_q),
		.clkout_port_pin_q(clkout_port_pin_q), .clkout_port_oe_q(clkout_port_oe_q),
		.tone_port_pin_q(tone_port_pin_q), .tone_port_oe_q(tone_port_oe_q), .irq_q(irq_q));
	task complete_run;
		begin
			$display("checks %0d errors %0d", checks, errors);
			if (errors == 0 && checks > 0) begin
				$display("verification passed");
			end else begin
				$display("verification failed");
			end
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// Request held until waitrequest is seen low at an edge
	task acc(input w, input [9:0] a, input [7:0] d);
		begin
			@(posedge mclk);
			address <= a;
			writedata <= {24'h00_0000, d};
			read <= !w;
			write <= w;
			@(posedge mclk);
			while (waitrequest_q !== 1'b0) begin
				@(posedge mclk);
			end
			rd = readdata_q;
			read <= 1'b0;
			write <= 1'b0;
		end
	endtask
	// Time of the next rising tick request, in cycles
	task wait_tick;
		begin
			while (tick_irq_q !== 1'b0) begin
				@(posedge mclk);
			end
			while (tick_irq_q !== 1'b1) begin
				@(posedge mclk);
			end
			t1 = $time / 20;
		end
	endtask
	task tone_half;
		begin
			last = tone_port_pin_q;
			while (tone_port_pin_q === last) begin
				@(posedge mclk);
			end
			last = tone_port_pin_q;
			n = 0;
			while (tone_port_pin_q === last) begin
				n = n + 1;
				@(posedge mclk);
			end
		end
	endtask
	task count_en;
		begin
			repeat (16) @(posedge mclk);
			n = 0;
			repeat (64) begin
				@(posedge mclk);
				n = n + core_clk_en_q;
			end
		end
	endtask
	task halt_pulse;
		begin
			@(posedge mclk);
			halt_req <= 1'b1;
			@(posedge mclk);
			halt_req <= 1'b0;
			@(posedge mclk);
		end
	endtask
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			complete_run;
		end
	end
	initial begin
		{reset_n, read, write, halt_req, ext_wake} = 5'h00;
		irq_mask = 1'b1;
		address = 10'h000;
		writedata = 32'h0000_0000;
		{errors, checks, cyc} = 0;
		per[0] = 40;
		per[1] = 80;
		per[2] = 200;
		per[3] = 500;
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		acc(0, 10'h0B0, 8'h00);
		chk(rd, 0);
		acc(0, 10'h0B4, 8'h00);
		chk(rd, 0);
		acc(1, 10'h3FC, 8'hFF);
		acc(0, 10'h3FC, 8'h00);
		chk(rd, 0);
		irq_mask <= 1'b0;
		$display("test reset done");
		acc(1, 10'h0B0, 8'h02);
		wait_tick;
		t0 = t1;
		acc(0, 10'h0B0, 8'h00);
		chk(rd, 8'h03);
		for (i = 1; i < 4; i = i + 1) begin
			acc(1, 10'h0B0, 8'h03 | (i << 2));
			acc(0, 10'h0B0, 8'h00);
			chk(rd, 8'h02 | (i << 2));
			wait_tick;
			chk(t1 - t0, per[i - 1]);
			t0 = t1;
			acc(0, 10'h0B0, 8'h00);
			wait_tick;
			chk(t1 - t0, per[i]);
			t0 = t1;
			acc(0, 10'h0B0, 8'h00);
			chk(rd[0], 1);
		end
		$display("test tick done");
		acc(1, 10'h0C8, 8'h01);
		repeat (2) @(posedge mclk);
		chk(irq_q, 1);
		acc(1, 10'h0C8, 8'h00);
		repeat (2) @(posedge mclk);
		chk(irq_q, 0);
		acc(1, 10'h0C8, 8'h01);
		acc(1, 10'h0C4, 8'h03);
		repeat (2) @(posedge mclk);
		chk(irq_q, 0);
		acc(0, 10'h0C0, 8'h00);
		chk(rd, 0);
		$display("test events done");
		acc(1, 10'h0B0, 8'h8E);
		count_en;
		chk(n, 64);
		chk(clkout_port_oe_q, 1);
		for (i = 0; i < 4; i = i + 1) begin
			acc(1, 10'h0B0, 8'h9E | (i << 5));
			count_en;
			chk(n, 64 >> (i + 1));
		end
		acc(1, 10'h0B0, 8'h8E);
		$display("test clock done");
		for (i = 1; i < 4; i = i + 1) begin
			acc(1, 10'h0B4, i);
			tone_half;
			chk(n, 2 << i);
			chk(tone_port_oe_q, 1);
		end
		acc(1, 10'h0B4, 8'h01);
		$display("test tone done");
		acc(0, 10'h0B0, 8'h00);
		wait_tick;
		irq_mask <= 1'b1;
		repeat (2) @(posedge mclk);
		chk(tick_irq_q, 0);
		irq_mask <= 1'b0;
		acc(0, 10'h0B0, 8'h00);
		chk(rd, 8'h8F);
		halt_pulse;
		chk(timed_halt_q, 1);
		tone_half;
		chk(n, 4);
		chk(clkout_port_pin_q, 0);
		while (timed_halt_q !== 1'b0) begin
			@(posedge mclk);
		end
		chk(timed_halt_q, 0);
		acc(0, 10'h0C0, 8'h00);
		chk(rd[1], 1);
		acc(1, 10'h0B0, 8'h0C);
		acc(0, 10'h0B0, 8'h00);
		chk(rd, 8'h0D);
		acc(1, 10'h0B4, 8'h00);
		repeat (2) @(posedge mclk);
		chk(tone_port_oe_q, 0);
		chk(clkout_port_oe_q, 0);
		halt_pulse;
		chk(full_halt_q, 1);
		repeat (600) @(posedge mclk);
		chk(full_halt_q, 1);
		ext_wake <= 1'b1;
		@(posedge mclk);
		ext_wake <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(full_halt_q, 0);
		acc(0, 10'h0B0, 8'h00);
		chk(rd, 8'h0C);
		acc(1, 10'h0B0, 8'h0E);
		halt_pulse;
		chk(timed_halt_q, 1);
		ext_wake <= 1'b1;
		@(posedge mclk);
		ext_wake <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(timed_halt_q, 0);
		$display("test halt done");
		complete_run;
	end
endmodule // tb_top
